/* File: core/pmrw_pin_filter.sv */
// Pin synchroniser with a stable-level filter and a low-width qualifier.
// Assumes the pin is asynchronous to clk_sys_in.
`default_nettype none

module pmrw_pin_filter
  import pmrw_pkg::*;
#(
  parameter int unsigned MIN_CYC = 1,
  parameter logic        RST_LVL = 1'b1
) (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic srst_in,
  // Pin
  input  wire logic pin_in,
  // Filtered results
  output logic      level_out,
  output logic      low_ok_out
);

  localparam int unsigned CW = $clog2(MIN_CYC + 1);

  typedef struct packed {
    logic          s1;
    logic          s2;
    logic          s3;
    logic          lvl;
    logic [CW-1:0] cnt;
    logic          low_ok;
  } pmrw_flt_t;

  pmrw_flt_t st;
  pmrw_flt_t next_st;

  // ==========================================================================
  // Three stages; level moves only when stages two and three agree
  always_comb begin
    next_st    = st;
    next_st.s1 = pin_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.lvl = st.s3;
    end
    // Count filtered low cycles up to the qualifying width
    if (st.lvl) begin
      next_st.cnt    = '0;
      next_st.low_ok = 1'b0;
    end else if (st.cnt == CW'(MIN_CYC - 1)) begin
      next_st.low_ok = 1'b1;
    end else begin
      next_st.cnt = st.cnt + CW'(1);
    end
  end

  // Register the whole state
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      st <= '{s1: RST_LVL, s2: RST_LVL, s3: RST_LVL, lvl: RST_LVL, cnt: '0, low_ok: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign level_out  = st.lvl;
  assign low_ok_out = st.low_ok;

endmodule

`default_nettype wire

/* File: core/pmrw_top.sv */
// Power mode, reset and wake controller: mode sequencing, reset sources,
// start logic, supply droop monitoring, readout lock decode, clock gating.
// Assumes clk_sys_in keeps running in every mode; the gating outputs drive
// the real clock and power switches outside this block.
`default_nettype none

module pmrw_top
  import pmrw_pkg::*;
#(
  parameter int unsigned NPINS = START_PINS,
  parameter int unsigned NPER  = PERIPHS
) (
  // Clock and reset (reset acts as power-on detection)
  input  wire logic                   clk_sys_in,
  input  wire logic                   srst_in,
  // External pins
  input  wire logic                   reset_pin_n_in,
  input  wire logic                   wake_pin_n_in,
  input  wire logic                   boot_select_pin_in,
  input  wire logic [NPINS-1:0]       start_pins_in,
  // Start logic configuration
  input  wire logic [NPINS-1:0]       start_en_in,
  input  wire logic [NPINS-1:0]       start_rise_in,
  // Mode requests from the core
  input  wire logic                   sleep_req_in,
  input  wire logic                   deep_req_in,
  input  wire logic                   dpd_req_in,
  input  wire logic                   irq_pending_in,
  input  wire logic                   keep_wdosc_in,
  input  wire logic                   keep_droop_in,
  // Other reset sources
  input  wire logic                   wdt_reset_in,
  input  wire logic [CAUSE_W-1:0]     cause_clr_in,
  // Supply droop comparators and selection
  input  wire logic [DROOP_LEVELS-1:0] droop_below_in,
  input  wire logic [DROOP_SEL_W-1:0]  droop_irq_sel_in,
  input  wire logic [DROOP_SEL_W-1:0]  droop_rst_sel_in,
  input  wire logic                   droop_rst_en_in,
  // Clock control
  input  wire logic [NPER-1:0]        periph_clk_en_in,
  input  wire logic                   clk_src_switch_in,
  // Flash lock word
  input  wire logic [31:0]            lock_word_in,
  // Power and clock switches
  output logic                        core_clk_en_out,
  output logic                        analog_pwr_en_out,
  output logic                        irc_run_out,
  output logic                        wdosc_run_out,
  output logic                        droop_det_run_out,
  output logic                        main_pwr_en_out,
  output logic                        clk_src_irc_out,
  output logic [NPER-1:0]             periph_clk_out,
  // Reset outputs
  output logic                        chip_rst_out,
  output logic                        flash_init_out,
  output logic                        exec_start_out,
  output logic [31:0]                 boot_vector_out,
  output logic [CAUSE_W-1:0]          reset_cause_out,
  // Interrupt lines and status
  output logic [NPINS-1:0]            start_irq_out,
  output logic                        droop_irq_out,
  output logic                        droop_status_out,
  // Access control
  output logic                        swd_en_out,
  output logic                        isp_en_out,
  output logic                        isp_partial_out,
  output logic                        isp_erase_only_out,
  output logic                        sector0_lock_out,
  output logic                        enter_boot_out,
  output logic                        app_prog_en_out,
  output logic [1:0]                  lock_level_out
);

  typedef struct packed {
    pmrw_pstate_t           pstate;
    logic [RST_CNT_W-1:0]   hold;
    pmrw_pwr_t              pwr;
    logic                   irc_sel;
    logic [NPER-1:0]        periph;
    logic                   exec_start;
    logic [31:0]            vector;
    logic [CAUSE_W-1:0]     cause;
    logic [NPINS-1:0]       start_prev;
    logic [NPINS-1:0]       start_irq;
    logic                   droop_irq;
    logic                   droop_stat;
    pmrw_access_t           acc;
    logic                   enter_boot;
    logic                   app_prog;
  } pmrw_state_t;

  pmrw_state_t st;
  pmrw_state_t next_st;

  logic [NPINS-1:0]        start_lvl;
  logic [NPINS-1:0]        start_hit;
  logic [DROOP_LEVELS-1:0] droop_lvl;
  logic                    rst_pin_low;
  logic                    wake_low;
  logic                    boot_lvl;
  logic                    droop_rst;
  logic                    any_rst;

  // ==========================================================================
  // Pin filters
  // Reset and wake pins qualify a low of the least width
  pmrw_pin_filter #(.MIN_CYC(PIN_MIN_CYC), .RST_LVL(1'b1)) u_rst_pin (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .pin_in     (reset_pin_n_in),
    .level_out  (),
    .low_ok_out (rst_pin_low)
  );

  pmrw_pin_filter #(.MIN_CYC(PIN_MIN_CYC), .RST_LVL(1'b1)) u_wake_pin (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .pin_in     (wake_pin_n_in),
    .level_out  (),
    .low_ok_out (wake_low)
  );

  pmrw_pin_filter #(.MIN_CYC(1), .RST_LVL(1'b1)) u_boot_pin (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .pin_in     (boot_select_pin_in),
    .level_out  (boot_lvl),
    .low_ok_out ()
  );

  // Start pins: per pin filter and edge detect on the free-running clock,
  // so detection never waits on the gated core or peripheral clocks
  for (genvar i = 0; i < NPINS; i++) begin : g_start
    pmrw_pin_filter #(.MIN_CYC(1), .RST_LVL(1'b0)) u_flt (
      .clk_sys_in (clk_sys_in),
      .srst_in    (srst_in),
      .pin_in     (start_pins_in[i]),
      .level_out  (start_lvl[i]),
      .low_ok_out ()
    );
    assign start_hit[i] = start_en_in[i] & (start_rise_in[i] ?
                          (start_lvl[i] & ~st.start_prev[i]) :
                          (~start_lvl[i] & st.start_prev[i]));
  end

  // Droop comparators are analog, so treat them as asynchronous
  for (genvar j = 0; j < DROOP_LEVELS; j++) begin : g_droop
    pmrw_pin_filter #(.MIN_CYC(1), .RST_LVL(1'b0)) u_flt (
      .clk_sys_in (clk_sys_in),
      .srst_in    (srst_in),
      .pin_in     (droop_below_in[j]),
      .level_out  (droop_lvl[j]),
      .low_ok_out ()
    );
  end

  // ==========================================================================
  // Reset sources
  // Detector output only counts while it is powered
  assign droop_rst = st.pwr.droop_run & droop_rst_en_in & droop_lvl[droop_rst_sel_in];
  // Chip is unpowered in deep power-down, so only the wake pin matters there
  assign any_rst = (st.pstate != PS_DPD) & (rst_pin_low | wdt_reset_in | droop_rst);

  // ==========================================================================
  // Helpers
  // Power switches for each mode
  function automatic pmrw_pwr_t pwr_of(input pmrw_pstate_t ps, input logic kw,
                                       input logic kd);
    pmrw_pwr_t p;
    p = '{core_clk_en: 1'b0, analog_en: 1'b1, irc_run: 1'b1, wdosc_run: 1'b1,
          droop_run: 1'b1, main_pwr_en: 1'b1};
    case (ps)
      PS_RUN: begin
        p.core_clk_en = 1'b1;
      end
      PS_SLEEP: begin
        p.core_clk_en = 1'b0;
      end
      PS_DSLEEP: begin
        p.analog_en = 1'b0;
        p.irc_run   = 1'b0;
        p.wdosc_run = kw;
        p.droop_run = kd;
      end
      PS_DPD: begin
        p = '0;
      end
      default: begin
        p.irc_run = 1'b1;
      end
    endcase
    return p;
  endfunction

  // Lock word decode; application programming is never part of it
  function automatic pmrw_access_t decode(input logic [31:0] w);
    pmrw_access_t a;
    a = '{swd_en: 1'b1, isp_en: 1'b1, isp_partial: 1'b0, isp_erase_only: 1'b0,
          sector0_lock: 1'b0, pin_boot_ok: 1'b1, level: LOCK_LVL_NONE};
    case (w)
      LOCK_PAT_ONE: begin
        a.swd_en       = 1'b0;
        a.isp_partial  = 1'b1;
        a.sector0_lock = 1'b1;
        a.level        = LOCK_LVL_ONE;
      end
      LOCK_PAT_TWO: begin
        a.swd_en         = 1'b0;
        a.isp_erase_only = 1'b1;
        a.level          = LOCK_LVL_TWO;
      end
      LOCK_PAT_THREE: begin
        a.swd_en      = 1'b0;
        a.isp_en      = 1'b0;
        a.pin_boot_ok = 1'b0;
        a.level       = LOCK_LVL_THREE;
      end
      NO_BOOT_PAT: begin
        a.pin_boot_ok = 1'b0;
      end
      default: begin
        a.level = LOCK_LVL_NONE;
      end
    endcase
    return a;
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    next_st            = st;
    next_st.exec_start = 1'b0;
    next_st.start_prev = start_lvl;
    next_st.start_irq  = '0;
    // Hardware sets win over a clear in the same cycle
    next_st.cause = st.cause & ~cause_clr_in;
    // Start pins act as interrupts whenever the chip is powered and not in reset
    if (st.pstate == PS_RUN || st.pstate == PS_SLEEP || st.pstate == PS_DSLEEP) begin
      next_st.start_irq = start_hit;
    end
    // Droop interrupt and status follow the selected level while powered and out of reset
    next_st.droop_irq  = st.pwr.droop_run & droop_lvl[droop_irq_sel_in];
    next_st.droop_stat = st.pwr.droop_run & droop_lvl[droop_irq_sel_in];
    case (st.pstate)
      PS_RESET: begin
        if (st.hold == RST_CNT_W'(RST_HOLD_CYC - 1)) begin
          next_st.pstate     = PS_RUN;
          next_st.exec_start = 1'b1;
          next_st.acc        = decode(lock_word_in);
          next_st.enter_boot = ~boot_lvl & next_st.acc.pin_boot_ok;
        end else begin
          next_st.hold = st.hold + RST_CNT_W'(1);
        end
      end
      PS_RUN: begin
        if (clk_src_switch_in) begin
          next_st.irc_sel = 1'b0;
        end
        if (dpd_req_in) begin
          next_st.pstate = PS_DPD;
        end else if (deep_req_in) begin
          next_st.pstate = PS_DSLEEP;
        end else if (sleep_req_in) begin
          next_st.pstate = PS_SLEEP;
        end
      end
      PS_SLEEP: begin
        if (irq_pending_in) begin
          next_st.pstate = PS_RUN;
        end
      end
      PS_DSLEEP: begin
        if ((|start_hit) || irq_pending_in) begin
          next_st.pstate = PS_RUN;
        end
      end
      PS_DPD: begin
        if (wake_low) begin
          next_st.pstate = PS_RESET;
          next_st.hold   = '0;
          next_st.irc_sel = 1'b1;
          next_st.acc    = ACCESS_RST;
          next_st.enter_boot = 1'b0;
          next_st.start_irq  = '0;
        end
      end
      default: begin
        next_st.pstate = PS_RESET;
        next_st.hold   = '0;
      end
    endcase
    // Any reset source restarts the hold, so a held pin stretches reset
    if (any_rst) begin
      next_st.pstate     = PS_RESET;
      next_st.hold       = '0;
      next_st.irc_sel    = 1'b1;
      next_st.acc        = ACCESS_RST;
      next_st.enter_boot = 1'b0;
      next_st.start_irq  = '0;
      next_st.exec_start = 1'b0;
      next_st.cause[CAUSE_PIN]   = next_st.cause[CAUSE_PIN] | rst_pin_low;
      next_st.cause[CAUSE_WDT]   = next_st.cause[CAUSE_WDT] | wdt_reset_in;
      next_st.cause[CAUSE_DROOP] = next_st.cause[CAUSE_DROOP] | droop_rst;
    end
    // Outputs follow the next mode so they change together with it
    next_st.pwr = pwr_of(next_st.pstate, keep_wdosc_in, keep_droop_in);
    if (next_st.pstate == PS_RUN || next_st.pstate == PS_SLEEP) begin
      next_st.periph = periph_clk_en_in;
    end else begin
      next_st.periph = '0;
    end
    next_st.droop_irq  = next_st.droop_irq & (next_st.pstate != PS_RESET);
    next_st.droop_stat = next_st.droop_stat & (next_st.pstate != PS_RESET);
  end

  // ==========================================================================
  // State register; power-on reset loads constants only
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      st <= '{pstate: PS_RESET, hold: '0,
              pwr: '{core_clk_en: 1'b0, analog_en: 1'b1, irc_run: 1'b1, wdosc_run: 1'b1,
                     droop_run: 1'b1, main_pwr_en: 1'b1},
              irc_sel: 1'b1, periph: '0, exec_start: 1'b0, vector: BOOT_VECTOR,
              cause: CAUSE_W'(1) << CAUSE_POR, start_prev: '0, start_irq: '0,
              droop_irq: 1'b0, droop_stat: 1'b0, acc: ACCESS_RST, enter_boot: 1'b0,
              app_prog: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs, all straight from the state register
  assign core_clk_en_out    = st.pwr.core_clk_en;
  assign analog_pwr_en_out  = st.pwr.analog_en;
  assign irc_run_out        = st.pwr.irc_run;
  assign wdosc_run_out      = st.pwr.wdosc_run;
  assign droop_det_run_out  = st.pwr.droop_run;
  assign main_pwr_en_out    = st.pwr.main_pwr_en;
  assign clk_src_irc_out    = st.irc_sel;
  assign periph_clk_out     = st.periph;
  assign chip_rst_out       = st.pstate[0];
  // Flash controller stays in init for the whole reset hold
  assign flash_init_out     = st.pstate[0];
  assign exec_start_out     = st.exec_start;
  assign boot_vector_out    = st.vector;
  assign reset_cause_out    = st.cause;
  assign start_irq_out      = st.start_irq;
  assign droop_irq_out      = st.droop_irq;
  assign droop_status_out   = st.droop_stat;
  assign swd_en_out         = st.acc.swd_en;
  assign isp_en_out         = st.acc.isp_en;
  assign isp_partial_out    = st.acc.isp_partial;
  assign isp_erase_only_out = st.acc.isp_erase_only;
  assign sector0_lock_out   = st.acc.sector0_lock;
  assign enter_boot_out     = st.enter_boot;
  assign app_prog_en_out    = st.app_prog;
  assign lock_level_out     = st.acc.level;

endmodule

`default_nettype wire

/* File: include/pmrw_pkg.sv */
// Shared constants and types for the power mode, reset and wake controller.
// Assumes a single 50 MHz system clock that keeps running in every mode.
`default_nettype none

package pmrw_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned START_PINS   = 13;
  localparam int unsigned PERIPHS      = 16;
  localparam int unsigned DROOP_LEVELS = 4;
  localparam int unsigned DROOP_SEL_W  = 2;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_MHZ      = 50;
  localparam int unsigned PIN_MIN_NS   = 50;
  // Least width, so round up
  localparam int unsigned PIN_MIN_CYC  = (PIN_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RST_HOLD_CYC = 4;
  localparam int unsigned RST_CNT_W    = 3;
  localparam int unsigned IRC_MHZ      = 12;

  // ==========================================================================
  // Boot and lock words
  localparam logic [31:0] BOOT_VECTOR   = 32'h0000_0000;
  localparam logic [31:0] LOCK_PAT_ONE  = 32'h0000_1111;
  localparam logic [31:0] LOCK_PAT_TWO  = 32'h0000_2222;
  localparam logic [31:0] LOCK_PAT_THREE = 32'h0000_3333;
  localparam logic [31:0] NO_BOOT_PAT   = 32'h0000_4444;

  localparam logic [1:0] LOCK_LVL_NONE  = 2'h0;
  localparam logic [1:0] LOCK_LVL_ONE   = 2'h1;
  localparam logic [1:0] LOCK_LVL_TWO   = 2'h2;
  localparam logic [1:0] LOCK_LVL_THREE = 2'h3;

  // ==========================================================================
  // Reset cause bit positions
  localparam int unsigned CAUSE_W     = 4;
  localparam int unsigned CAUSE_POR   = 0;
  localparam int unsigned CAUSE_PIN   = 1;
  localparam int unsigned CAUSE_WDT   = 2;
  localparam int unsigned CAUSE_DROOP = 3;

  // ==========================================================================
  // Types
  typedef enum logic [4:0] {
    PS_RESET  = 5'h01,
    PS_RUN    = 5'h02,
    PS_SLEEP  = 5'h04,
    PS_DSLEEP = 5'h08,
    PS_DPD    = 5'h10
  } pmrw_pstate_t;

  typedef struct packed {
    logic core_clk_en;
    logic analog_en;
    logic irc_run;
    logic wdosc_run;
    logic droop_run;
    logic main_pwr_en;
  } pmrw_pwr_t;

  typedef struct packed {
    logic       swd_en;
    logic       isp_en;
    logic       isp_partial;
    logic       isp_erase_only;
    logic       sector0_lock;
    logic       pin_boot_ok;
    logic [1:0] level;
  } pmrw_access_t;

  localparam pmrw_access_t ACCESS_RST = '{swd_en: 1'b0, isp_en: 1'b0, isp_partial: 1'b0,
                                          isp_erase_only: 1'b0, sector0_lock: 1'b1,
                                          pin_boot_ok: 1'b0, level: LOCK_LVL_NONE};

endpackage

`default_nettype wire

/* File: test/pmrw_pins.sv */
// External reset and wake pins, each with a pull-up.
// Assumes tasks are called just after a clock edge.
`default_nettype none
module pmrw_pins (
  // Clock and pins
  input  wire logic clk_sys_in,
  output logic      reset_pin_n_out,
  output logic      wake_pin_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-ups keep both pins high when nobody drives them
  initial begin
    reset_pin_n_out = 1'b1;
    wake_pin_n_out = 1'b1;
  end
  // Low pulse of n cycles; released back to the pull-up level
  task automatic pulse(input logic wk, input int n);
    if (wk) wake_pin_n_out = 1'b0;
    else reset_pin_n_out = 1'b0;
    repeat (n) @(posedge clk_sys_in);
    #2;
    wake_pin_n_out = 1'b1;
    reset_pin_n_out = 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: test/pmrw_props.sv */
// Port-level checks for the power mode, reset and wake controller.
// Assumes one clock domain and the synchronous active-high reset.
`default_nettype none
module pmrw_props
  import pmrw_pkg::*;
#(
  parameter int unsigned NPINS = START_PINS,
  parameter int unsigned NPER  = PERIPHS
) (
  // Clock, reset, pins and requests
  input wire logic clk_sys_in, srst_in, reset_pin_n_in, wake_pin_n_in,
  input wire logic [NPINS-1:0] start_pins_in, start_en_in, start_rise_in, start_irq_out,
  input wire logic sleep_req_in, deep_req_in, dpd_req_in, irq_pending_in, wdt_reset_in,
  input wire logic [DROOP_LEVELS-1:0] droop_below_in,
  input wire logic [DROOP_SEL_W-1:0]  droop_irq_sel_in,
  input wire logic [NPER-1:0]         periph_clk_en_in, periph_clk_out,
  // Outputs under watch
  input wire logic core_clk_en_out, analog_pwr_en_out, irc_run_out, wdosc_run_out,
  input wire logic droop_det_run_out, main_pwr_en_out, clk_src_irc_out, chip_rst_out,
  input wire logic flash_init_out, exec_start_out, droop_irq_out, droop_status_out,
  input wire logic swd_en_out, isp_en_out, enter_boot_out, app_prog_en_out,
  input wire logic isp_partial_out, isp_erase_only_out, sector0_lock_out,
  input wire logic [31:0]             boot_vector_out,
  input wire logic [1:0]              lock_level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  // ==========================================================================
  // Mode, reset and access relations
  req_stops_core_a: assert property (
    (sleep_req_in || deep_req_in || dpd_req_in) && core_clk_en_out |=> !core_clk_en_out)
    else $error("core clock not stopped");
  // Wdt excluded: a reset in sleep takes the other path
  sleep_wake_a: assert property (
    !core_clk_en_out && analog_pwr_en_out && !chip_rst_out && irq_pending_in && !wdt_reset_in
    |=> core_clk_en_out) else $error("sleep not left on interrupt");
  deep_sleep_a: assert property (
    main_pwr_en_out && !analog_pwr_en_out |-> !core_clk_en_out && !irc_run_out)
    else $error("deep-sleep left blocks on");
  power_off_a: assert property (
    !main_pwr_en_out |-> !(core_clk_en_out || analog_pwr_en_out || irc_run_out
    || wdosc_run_out || droop_det_run_out)) else $error("block alive in power-down");
  // Three low samples are a qualifying pulse; the filter needs up to 8 more
  off_wake_a: assert property (
    (!main_pwr_en_out && !wake_pin_n_in) [*3] |-> ##[1:8] main_pwr_en_out)
    else $error("wake pin ignored");
  wake_resets_a: assert property (
    $rose(main_pwr_en_out) |-> chip_rst_out) else $error("wake skips reset path");
  reset_path_a: assert property (
    chip_rst_out |-> flash_init_out && irc_run_out && clk_src_irc_out && !core_clk_en_out)
    else $error("reset without oscillator or flash init");
  pin_reset_a: assert property (
    (main_pwr_en_out && !reset_pin_n_in) [*3] |-> ##[1:8] chip_rst_out)
    else $error("reset pin ignored");
  release_a: assert property (
    $fell(chip_rst_out) |-> exec_start_out && core_clk_en_out
    && boot_vector_out == BOOT_VECTOR) else $error("bad reset release");
  start_irq_a: assert property (
    main_pwr_en_out && $rose(start_pins_in[0]) && start_en_in[0] && start_rise_in[0]
    |-> ##[2:7] start_irq_out[0]) else $error("start edge lost");
  droop_a: assert property (
    (droop_below_in[droop_irq_sel_in] && droop_det_run_out && !chip_rst_out) [*7]
    |-> droop_irq_out && droop_status_out) else $error("droop not flagged");
  gate_a: assert property (
    core_clk_en_out && $past(core_clk_en_out) |-> periph_clk_out == $past(periph_clk_en_in))
    else $error("peripheral clock gate wrong");
  lock_a: assert property (
    !chip_rst_out && lock_level_out != LOCK_LVL_NONE |-> !swd_en_out && app_prog_en_out)
    else $error("debug open under lock");
  lock_grade_a: assert property (
    !chip_rst_out |-> isp_partial_out == (lock_level_out == LOCK_LVL_ONE)
    && sector0_lock_out == (lock_level_out == LOCK_LVL_ONE)
    && isp_erase_only_out == (lock_level_out == LOCK_LVL_TWO))
    else $error("bootloader grade wrong");
  lock_three_a: assert property (
    !chip_rst_out && lock_level_out == LOCK_LVL_THREE |-> !isp_en_out && !enter_boot_out)
    else $error("bootloader open at level three");
  cover property ($fell(core_clk_en_out));
  cover property ($rose(main_pwr_en_out));
  cover property (start_irq_out[0]);
endmodule
`default_nettype wire

/* File: test/power_mode_reset_wake_ctrl_test.sv */
// Self-checking bench for the power mode, reset and wake controller.
// Assumes the pin model holds reset and wake pins at their pull-up level.
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module power_mode_reset_wake_ctrl_test
  import pmrw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  int err_count = 0;
  int compares = 0;
  int i;
  logic clk_sys_in, srst_in, boot_select_pin_in, sleep_req_in, deep_req_in, dpd_req_in;
  logic irq_pending_in, keep_wdosc_in, keep_droop_in, wdt_reset_in, droop_rst_en_in;
  logic clk_src_switch_in, core_clk_en_out, analog_pwr_en_out, irc_run_out, wdosc_run_out;
  logic droop_det_run_out, main_pwr_en_out, clk_src_irc_out, chip_rst_out, flash_init_out;
  logic exec_start_out, droop_irq_out, droop_status_out, swd_en_out, isp_en_out;
  logic enter_boot_out, app_prog_en_out;
  wire logic reset_pin_n_in, wake_pin_n_in;
  logic [START_PINS-1:0] start_pins_in, start_en_in, start_rise_in, start_irq_out;
  logic [CAUSE_W-1:0] cause_clr_in, reset_cause_out;
  logic [DROOP_LEVELS-1:0] droop_below_in;
  logic [1:0] droop_irq_sel_in, droop_rst_sel_in, lock_level_out;
  logic [PERIPHS-1:0] periph_clk_en_in, periph_clk_out;
  logic [31:0] lock_word_in, boot_vector_out;
  pmrw_top u_dut (.*, .isp_partial_out(), .isp_erase_only_out(), .sector0_lock_out());
  pmrw_pins u_pins (.clk_sys_in, .reset_pin_n_out(reset_pin_n_in),
    .wake_pin_n_out(wake_pin_n_in));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #2;
  endtask
  task automatic complete_run();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  // Sequence needs some 90 cycles; 1000 cuts a hang short
  initial begin
    #20000;
    err_count++;
    complete_run();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    {sleep_req_in, deep_req_in, dpd_req_in, irq_pending_in, keep_wdosc_in} = '0;
    {keep_droop_in, wdt_reset_in, droop_rst_en_in, clk_src_switch_in} = '0;
    {boot_select_pin_in, start_pins_in, start_en_in, start_rise_in} = '0;
    {cause_clr_in, droop_below_in, droop_irq_sel_in, droop_rst_sel_in} = '0;
    periph_clk_en_in = '0;
    lock_word_in = LOCK_PAT_THREE;
    srst_in = 1'b1;
    tick(3);
    srst_in = 1'b0;
    tick(6);
    `CHK("run", 1'b1, core_clk_en_out)
    `CHK("level", LOCK_LVL_THREE, lock_level_out)
    `CHK("access", 1'b0, swd_en_out | isp_en_out | enter_boot_out)
    `CHK("cause", 4'h1, reset_cause_out)
    periph_clk_en_in = 16'hA5A5;
    clk_src_switch_in = 1'b1;
    tick(1);
    clk_src_switch_in = 1'b0;
    tick(1);
    `CHK("gate", 16'hA5A5, periph_clk_out)
    `CHK("src", 1'b0, clk_src_irc_out)
    wdt_reset_in = 1'b1;
    tick(1);
    wdt_reset_in = 1'b0;
    `CHK("wdt", 2'h3, {chip_rst_out, clk_src_irc_out})
    tick(6);
    `CHK("cause", 1'b1, reset_cause_out[CAUSE_WDT])
    sleep_req_in = 1'b1;
    tick(1);
    sleep_req_in = 1'b0;
    `CHK("sleep", 1'b0, core_clk_en_out)
    tick(3);
    `CHK("periph", 16'hA5A5, periph_clk_out)
    irq_pending_in = 1'b1;
    tick(1);
    irq_pending_in = 1'b0;
    `CHK("resume", 1'b1, core_clk_en_out)
    {keep_wdosc_in, start_en_in[0], start_rise_in[0]} = 3'h7;
    // Reset left the clock on the RC osc, so deep-sleep is safe
    deep_req_in = 1'b1;
    tick(1);
    deep_req_in = 1'b0;
    `CHK("deep", 2'h1, {analog_pwr_en_out, wdosc_run_out})
    start_pins_in[0] = 1'b1;
    for (i = 0; i < 20 && !core_clk_en_out; i++) tick(1);
    `CHK("wake", 1'b1, core_clk_en_out)
    start_pins_in[0] = 1'b0;
    tick(8);
    start_pins_in[0] = 1'b1;
    for (i = 0; i < 10 && start_irq_out[0] !== 1'b1; i++) tick(1);
    `CHK("irq", 1'b1, start_irq_out[0])
    // New lock word is only taken at the next reset release
    lock_word_in = LOCK_PAT_ONE;
    dpd_req_in = 1'b1;
    tick(1);
    dpd_req_in = 1'b0;
    `CHK("off", 1'b0, main_pwr_en_out)
    u_pins.pulse(1'b1, 3);
    for (i = 0; i < 30 && !core_clk_en_out; i++) tick(1);
    `CHK("dpd wake", 2'h3, {core_clk_en_out, clk_src_irc_out})
    `CHK("lock one", 3'h3, {lock_level_out, enter_boot_out})
    u_pins.pulse(1'b0, 4);
    for (i = 0; i < 12 && chip_rst_out !== 1'b1; i++) tick(1);
    `CHK("pin rst", 1'b1, chip_rst_out)
    tick(12);
    `CHK("cause", 1'b1, reset_cause_out[CAUSE_PIN])
    // Watchdog set must win over a clear in the same cycle
    cause_clr_in = 4'hF;
    wdt_reset_in = 1'b1;
    tick(1);
    cause_clr_in = 4'h0;
    wdt_reset_in = 1'b0;
    `CHK("clear", 4'h4, reset_cause_out)
    droop_irq_sel_in = 2'h1;
    droop_below_in = 4'h2;
    tick(8);
    `CHK("droop", 2'h3, {droop_irq_out, droop_status_out})
    droop_below_in = 4'h1;
    tick(8);
    `CHK("droop", 2'h0, {droop_irq_out, droop_status_out})
    complete_run();
  end
endmodule
bind pmrw_top pmrw_props #(.NPINS(NPINS), .NPER(NPER)) u_props (.*);
`default_nettype wire
